// >>> design/mmvd_regs.svh
`ifndef MMVD_REGS_SVH
`define MMVD_REGS_SVH

// ----------------------------------------
// address map
// ----------------------------------------
`define MMVD_DP_LO        16'h0000
`define MMVD_DP_HI        16'h007F
`define MMVD_HP_LO        16'h1800
`define MMVD_HP_HI        16'h185F
`define MMVD_NV_LO        16'hFFB0
`define MMVD_NV_HI        16'hFFBF
`define MMVD_VEC_LO       16'hFFC0
`define MMVD_VEC_HI       16'hFFFF

// ----------------------------------------
// nonvolatile block layout (offset in block)
// ----------------------------------------
`define MMVD_NV_KEY0      4'h0
`define MMVD_NV_KEY_LAST  4'h7
`define MMVD_NV_PROT      4'hD
`define MMVD_NV_OPT       4'hF

// ----------------------------------------
// vector pairs (high byte address)
// ----------------------------------------
`define MMVD_VEC_RESET    16'hFFFE
`define MMVD_VEC_SWI      16'hFFFC
`define MMVD_VEC_IRQ      16'hFFFA
`define MMVD_VEC_LVD      16'hFFF8

// ----------------------------------------
// reset values
// ----------------------------------------
`define MMVD_PROT_RST     8'hFF
`define MMVD_OPT_RST      8'hFF

`endif

// >>> design/mmvd_pkg.sv
`default_nettype none
package mmvd_pkg;
    typedef enum logic [3:0] {
        MMVD_REG_NONE = 4'b0001,
        MMVD_REG_DP   = 4'b0010,
        MMVD_REG_HP   = 4'b0100,
        MMVD_REG_NV   = 4'b1000
    } mmvd_region_t;

    typedef enum logic [3:0] {
        MMVD_VEC_RESET = 4'b0001,
        MMVD_VEC_SWI   = 4'b0010,
        MMVD_VEC_IRQ   = 4'b0100,
        MMVD_VEC_LVD   = 4'b1000
    } mmvd_vec_t;

    typedef enum logic [4:0] {
        MMVD_ST_LOAD_PROT = 5'b00001,
        MMVD_ST_LOAD_OPT  = 5'b00010,
        MMVD_ST_IDLE      = 5'b00100,
        MMVD_ST_VEC_HI    = 5'b01000,
        MMVD_ST_VEC_LO    = 5'b10000
    } mmvd_state_t;
endpackage
`default_nettype wire

// >>> design/mmvd_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmvd_regs.svh"

module mmvd_decode (
    input  wire logic [15:0]            addr_i,
    output var  mmvd_pkg::mmvd_region_t region_o,
    output logic [3:0]                  nv_off_o
);
    import mmvd_pkg::*;
    // ----------------------------------------
    // region decode, purely combinational
    // ----------------------------------------
    always_comb begin
        region_o = MMVD_REG_NONE;
        if (addr_i <= `MMVD_DP_HI) begin
            region_o = MMVD_REG_DP;
        end else if (addr_i >= `MMVD_HP_LO && addr_i <= `MMVD_HP_HI) begin
            region_o = MMVD_REG_HP;
        end else if (addr_i >= `MMVD_NV_LO && addr_i <= `MMVD_NV_HI) begin
            region_o = MMVD_REG_NV;
        end
    end

    assign nv_off_o = addr_i[3:0];
endmodule

`default_nettype wire

// >>> design/mmvd_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmvd_regs.svh"

// Contract
// - addresses 0x0000 to 0x007F select the direct-page register group.
// - addresses 0x1800 to 0x185F select the high-page register group.
// - addresses 0xFFB0 to 0xFFBF select the 16-byte nonvolatile block held in flash.
// - on every reset the protect and option bytes are copied from flash to working registers.
// - the nonvolatile block holds an eight-byte backdoor key exposed to security logic.
// - vectors are fetched high byte then low byte at FFFE, FFFC, FFFA and FFF8.
// - a direct access supplies only the low address byte and the high byte is zero.
// - bit set, clear and test act on any single bit of a direct-page register.
// - unused bits specified as zero read 0, except in the rdata_o value returned by a bit set on such a bit.
module mmvd_map (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // core access
    input  wire logic        acc_valid_i,
    input  wire logic        acc_write_i,
    input  wire logic        acc_direct_i,
    input  wire logic [15:0] acc_addr_i,
    input  wire logic [7:0]  acc_wdata_i,
    input  wire logic        acc_bit_op_i,
    input  wire logic [1:0]  acc_bit_cmd_i,
    input  wire logic [2:0]  acc_bit_sel_i,
    output logic             acc_ready_o,
    output logic             rdata_valid_o,
    output logic [7:0]       rdata_o,
    output logic             bit_test_o,
    // vector fetch
    input  wire logic        vec_req_i,
    input  wire mmvd_pkg::mmvd_vec_t vec_sel_i,
    output logic             vec_valid_o,
    output logic [15:0]      vec_addr_o,
    output logic [15:0]      vec_data_o,
    // flash array read port
    output logic [15:0]      fl_addr_o,
    input  wire logic [7:0]  fl_rdata_i,
    // register group port
    output logic             reg_sel_dp_o,
    output logic             reg_sel_hp_o,
    output logic             reg_we_o,
    output logic [15:0]      reg_addr_o,
    output logic [7:0]       reg_wdata_o,
    input  wire logic [7:0]  reg_rdata_i,
    input  wire logic [7:0]  reg_zero_mask_i,
    // working copies and key
    output logic [7:0]       flash_protect_byte_o,
    output logic [7:0]       flash_option_byte_o,
    output logic [63:0]      backdoor_key_o,
    output logic             load_done_o
);
    import mmvd_pkg::*;

    // upper twelve address bits of the nonvolatile block
    localparam logic [11:0] NV_PAGE = 12'(`MMVD_NV_LO >> 4);
    // ----------------------------------------
    // address forming and decode
    // ----------------------------------------
    logic [15:0]  eff_addr;
    mmvd_region_t region;

    assign eff_addr = acc_direct_i ? {8'h00, acc_addr_i[7:0]} : acc_addr_i;

    mmvd_decode u_dec (
        .addr_i   (eff_addr),
        .region_o (region),
        .nv_off_o ()
    );

    // ----------------------------------------
    // state
    // ----------------------------------------
    mmvd_state_t st_r, st_nxt;
    logic [7:0]  prot_r, prot_nxt, opt_r, opt_nxt;
    logic [63:0] key_r, key_nxt;
    logic [3:0]  kidx_r, kidx_nxt;
    logic [15:0] vaddr_r, vaddr_nxt, vdata_r, vdata_nxt;
    logic        vvalid_r, vvalid_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic        rvalid_r, rvalid_nxt, btest_r, btest_nxt;
    logic [7:0]  rd_byte, bit_mask, rmw;

    function automatic logic [15:0] vec_base(input mmvd_vec_t v);
        unique case (v)
            MMVD_VEC_RESET: vec_base = `MMVD_VEC_RESET;
            MMVD_VEC_SWI:   vec_base = `MMVD_VEC_SWI;
            MMVD_VEC_IRQ:   vec_base = `MMVD_VEC_IRQ;
            MMVD_VEC_LVD:   vec_base = `MMVD_VEC_LVD;
            default:        vec_base = `MMVD_VEC_RESET;
        endcase
    endfunction

    // ----------------------------------------
    // read data path
    // ----------------------------------------
    always_comb begin
        bit_mask = 8'h01 << acc_bit_sel_i;
        unique case (region)
            MMVD_REG_DP, MMVD_REG_HP: rd_byte = reg_rdata_i & ~reg_zero_mask_i;
            default:                  rd_byte = fl_rdata_i;
        endcase
        unique case (acc_bit_cmd_i)
            2'd0:    rmw = rd_byte | bit_mask;
            2'd1:    rmw = rd_byte & ~bit_mask;
            default: rmw = rd_byte;
        endcase
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt     = st_r;
        prot_nxt   = prot_r;
        opt_nxt    = opt_r;
        key_nxt    = key_r;
        kidx_nxt   = kidx_r;
        vaddr_nxt  = vaddr_r;
        vdata_nxt  = vdata_r;
        vvalid_nxt = 1'b0;
        rdata_nxt  = rdata_r;
        rvalid_nxt = 1'b0;
        btest_nxt  = btest_r;
        fl_addr_o  = eff_addr;
        unique case (st_r)
            MMVD_ST_LOAD_PROT: begin
                fl_addr_o = {NV_PAGE, `MMVD_NV_PROT};
                prot_nxt  = fl_rdata_i;
                st_nxt    = MMVD_ST_LOAD_OPT;
            end
            MMVD_ST_LOAD_OPT: begin
                if (kidx_r <= `MMVD_NV_KEY_LAST) begin
                    fl_addr_o = {NV_PAGE, kidx_r};
                    key_nxt   = {key_r[55:0], fl_rdata_i};
                    kidx_nxt  = kidx_r + 4'd1;
                end else begin
                    fl_addr_o = {NV_PAGE, `MMVD_NV_OPT};
                    opt_nxt   = fl_rdata_i;
                    st_nxt    = MMVD_ST_IDLE;
                end
            end
            MMVD_ST_IDLE: begin
                if (vec_req_i) begin
                    vaddr_nxt = vec_base(vec_sel_i);
                    st_nxt    = MMVD_ST_VEC_HI;
                end else if (acc_valid_i && (!acc_write_i || acc_bit_op_i)) begin
                    rdata_nxt  = acc_bit_op_i ? rmw : rd_byte;
                    btest_nxt  = |(rd_byte & bit_mask);
                    rvalid_nxt = 1'b1;
                end
            end
            MMVD_ST_VEC_HI: begin
                fl_addr_o       = vaddr_r;
                vdata_nxt[15:8] = fl_rdata_i;
                st_nxt          = MMVD_ST_VEC_LO;
            end
            MMVD_ST_VEC_LO: begin
                fl_addr_o      = vaddr_r + 16'h0001;
                vdata_nxt[7:0] = fl_rdata_i;
                vvalid_nxt     = 1'b1;
                st_nxt         = MMVD_ST_IDLE;
            end
            default: st_nxt = MMVD_ST_LOAD_PROT;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r     <= MMVD_ST_LOAD_PROT;
            prot_r   <= `MMVD_PROT_RST;
            opt_r    <= `MMVD_OPT_RST;
            key_r    <= 64'h0000_0000_0000_0000;
            kidx_r   <= `MMVD_NV_KEY0;
            vaddr_r  <= 16'h0000;
            vdata_r  <= 16'h0000;
            vvalid_r <= 1'b0;
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
            btest_r  <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            prot_r   <= prot_nxt;
            opt_r    <= opt_nxt;
            key_r    <= key_nxt;
            kidx_r   <= kidx_nxt;
            vaddr_r  <= vaddr_nxt;
            vdata_r  <= vdata_nxt;
            vvalid_r <= vvalid_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            btest_r  <= btest_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    logic idle;
    assign idle        = (st_r == MMVD_ST_IDLE);
    assign acc_ready_o = idle && !vec_req_i;
    // flash-backed locations take no plain writes
    assign reg_we_o     = acc_ready_o && acc_valid_i && (acc_write_i || acc_bit_op_i)
                          && (acc_write_i ? 1'b1 : acc_bit_cmd_i != 2'd2)
                          && (region == MMVD_REG_DP || region == MMVD_REG_HP);
    assign reg_sel_dp_o = acc_ready_o && acc_valid_i && region == MMVD_REG_DP;
    assign reg_sel_hp_o = acc_ready_o && acc_valid_i && region == MMVD_REG_HP;
    assign reg_addr_o   = eff_addr;
    assign reg_wdata_o  = acc_bit_op_i ? rmw : acc_wdata_i;

    assign rdata_o              = rdata_r;
    assign rdata_valid_o        = rvalid_r;
    assign bit_test_o           = btest_r;
    assign vec_addr_o           = vaddr_r;
    assign vec_data_o           = vdata_r;
    assign vec_valid_o          = vvalid_r;
    assign flash_protect_byte_o = prot_r;
    assign flash_option_byte_o  = opt_r;
    assign backdoor_key_o       = key_r;
    assign load_done_o          = idle || st_r == MMVD_ST_VEC_HI || st_r == MMVD_ST_VEC_LO;
endmodule

`default_nettype wire

// >>> tb/mmvd_map_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mmvd_map_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        acc_valid_i,
    input wire logic        acc_direct_i,
    input wire logic [15:0] acc_addr_i,
    input wire logic        acc_ready_o,
    input wire logic        rdata_valid_o,
    input wire logic [7:0]  rdata_o,
    input wire logic        vec_req_i,
    input wire logic        vec_valid_o,
    input wire logic [15:0] vec_addr_o,
    input wire logic        reg_sel_dp_o,
    input wire logic        reg_sel_hp_o,
    input wire logic        reg_we_o,
    input wire logic [15:0] reg_addr_o,
    input wire logic [7:0]  reg_zero_mask_i,
    input wire logic        load_done_o
);
    // ----------------------------------------
    // access, vector and load relations
    // ----------------------------------------
    logic [15:0] eff;
    logic        taken;
    assign eff = acc_direct_i ? {8'h00, acc_addr_i[7:0]} : acc_addr_i;
    assign taken = acc_valid_i && acc_ready_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_vec_start;
        $rose(vec_req_i) && load_done_o;
    endsequence
    sequence s_reg_answer;
        rdata_valid_o && $past(taken && (reg_sel_dp_o || reg_sel_hp_o));
    endsequence
    a_dp_select: assert property (taken && eff <= 16'h007F |->
        reg_sel_dp_o && reg_addr_o == eff) else $error("direct page not selected");
    a_dp_bound: assert property (taken && reg_sel_dp_o |-> reg_addr_o <= 16'h007F)
        else $error("direct page select out of range");
    a_hp_select: assert property (taken && !acc_direct_i && eff >= 16'h1800
        && eff <= 16'h185F |-> reg_sel_hp_o) else $error("high page not selected");
    a_nv_isolate: assert property (taken && !acc_direct_i && eff >= 16'hFFB0
        && eff <= 16'hFFBF |-> !(reg_sel_dp_o || reg_sel_hp_o || reg_we_o))
        else $error("nonvolatile access reached register groups");
    a_zero_bits: assert property (s_reg_answer |->
        (rdata_o & $past(reg_zero_mask_i)) == 8'h00) else $error("zero bit read as one");
    a_vec_walk: assert property (s_vec_start |-> ##3 vec_valid_o)
        else $error("vector answer late");
    a_vec_addr: assert property (vec_valid_o |-> vec_addr_o inside
        {16'hFFFE, 16'hFFFC, 16'hFFFA, 16'hFFF8}) else $error("vector base wrong");
    a_load_gate: assert property (!load_done_o || vec_req_i |-> !acc_ready_o)
        else $error("access taken during load or vector");
    a_load_len: assert property ($fell(rst_i) |-> !load_done_o ##9 !load_done_o ##1 load_done_o)
        else $error("load after reset wrong length");
endmodule
bind mmvd_map mmvd_map_checker i_chk (.clk_i, .rst_i, .acc_valid_i, .acc_direct_i,
    .acc_addr_i, .acc_ready_o, .rdata_valid_o, .rdata_o, .vec_req_i, .vec_valid_o,
    .vec_addr_o, .reg_sel_dp_o, .reg_sel_hp_o, .reg_we_o, .reg_addr_o,
    .reg_zero_mask_i, .load_done_o);
`default_nettype wire

// >>> tb/mmvd_core_mem.sv
`timescale 1ns/1ps
`default_nettype none
module mmvd_core_mem (
    input  wire logic        clk_i,
    input  wire logic [15:0] fl_addr_i,
    output logic [7:0]       fl_rdata_o,
    input  wire logic        sel_dp_i,
    input  wire logic        sel_hp_i,
    input  wire logic        we_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [7:0]  wdata_i,
    output logic [7:0]       rdata_o
);
    // ----------------------------------------
    // flash array and register groups
    // ----------------------------------------
    logic [7:0] mem [256] = '{default: 8'hA5};
    logic [7:0] idx;
    function automatic logic [7:0] fl_byte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    // flash has no write path: each byte is a fixed function of its address
    assign fl_rdata_o = fl_byte(fl_addr_i);
    assign idx = {sel_hp_i, addr_i[6:0]};
    // with neither group selected the output shows the inverse of the direct-page byte
    assign rdata_o = (sel_dp_i || sel_hp_i) ? mem[idx] : ~mem[idx];
    always @(posedge clk_i) begin
        if (we_i && (sel_dp_i || sel_hp_i)) begin
            mem[idx] <= wdata_i;
        end
    end
endmodule
`default_nettype wire

// >>> tb/mmvd_map_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mmvd_map_tb;
    import mmvd_pkg::*;
    // ----------------------------------------
    // bench
    // ----------------------------------------
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        acc_valid_i, acc_write_i, acc_direct_i, acc_bit_op_i, vec_req_i;
    logic [1:0]  acc_bit_cmd_i;
    logic [2:0]  acc_bit_sel_i;
    logic [7:0]  acc_wdata_i, reg_zero_mask_i, rdata_o, reg_wdata_o, reg_rdata_i, fl_rdata_i;
    logic [7:0]  flash_protect_byte_o, flash_option_byte_o, c_rd, c_wd;
    logic [15:0] acc_addr_i, vec_addr_o, vec_data_o, fl_addr_o, reg_addr_o, c_ad;
    logic [63:0] backdoor_key_o;
    logic        acc_ready_o, rdata_valid_o, bit_test_o, vec_valid_o, load_done_o;
    logic        reg_sel_dp_o, reg_sel_hp_o, reg_we_o, c_dp, c_hp, c_we, c_bt, c_rv;
    mmvd_vec_t   vec_sel_i = MMVD_VEC_RESET;
    int          n_errors = 0, tests_run = 0, cyc = 0;
    mmvd_map i_dut (.clk_i, .rst_i, .acc_valid_i, .acc_write_i, .acc_direct_i, .acc_addr_i,
        .acc_wdata_i, .acc_bit_op_i, .acc_bit_cmd_i, .acc_bit_sel_i, .acc_ready_o,
        .rdata_valid_o, .rdata_o, .bit_test_o, .vec_req_i, .vec_sel_i, .vec_valid_o,
        .vec_addr_o, .vec_data_o, .fl_addr_o, .fl_rdata_i, .reg_sel_dp_o, .reg_sel_hp_o,
        .reg_we_o, .reg_addr_o, .reg_wdata_o, .reg_rdata_i, .reg_zero_mask_i,
        .flash_protect_byte_o, .flash_option_byte_o, .backdoor_key_o, .load_done_o);
    mmvd_core_mem i_mem (.clk_i(clk_i), .fl_addr_i(fl_addr_o), .fl_rdata_o(fl_rdata_i),
        .sel_dp_i(reg_sel_dp_o), .sel_hp_i(reg_sel_hp_o), .we_i(reg_we_o),
        .addr_i(reg_addr_o), .wdata_i(reg_wdata_o), .rdata_o(reg_rdata_i));
    always #2.5 clk_i = ~clk_i;
    task automatic results();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    // holds the request until ready is high, captures strobes, then the answer
    task automatic acc(input int w, d, b, cm, bs, input logic [15:0] a, input logic [7:0] wd);
        @(negedge clk_i);
        {acc_valid_i, acc_write_i, acc_direct_i, acc_bit_op_i} = {1'b1, w[0], d[0], b[0]};
        {acc_bit_cmd_i, acc_bit_sel_i, acc_addr_i, acc_wdata_i} = {cm[1:0], bs[2:0], a, wd};
        #1;
        while (acc_ready_o !== 1'b1) @(negedge clk_i) #1;
        {c_dp, c_hp, c_we} = {reg_sel_dp_o, reg_sel_hp_o, reg_we_o};
        {c_ad, c_wd} = {reg_addr_o, reg_wdata_o};
        @(negedge clk_i);
        acc_valid_i = 1'b0;
        {c_rd, c_bt, c_rv} = {rdata_o, bit_test_o, rdata_valid_o};
    endtask
    task automatic t_load();
        logic [63:0] k;
        for (int i = 0; i < 8; i++) k = {k[55:0], i_mem.fl_byte(16'hFFB0 + 16'(i))};
        while (load_done_o !== 1'b1) @(negedge clk_i);
        chk("protect", 64'(i_mem.fl_byte(16'hFFBD)), 64'(flash_protect_byte_o));
        chk("option", 64'(i_mem.fl_byte(16'hFFBF)), 64'(flash_option_byte_o));
        chk("key", k, backdoor_key_o);
    endtask
    task automatic t_map();
        logic [15:0] t [8] = '{16'h0000, 16'h007F, 16'h0080, 16'h1800, 16'h185F, 16'h1860,
                               16'h17FF, 16'hFFC0};
        logic        e_dp, e_hp;
        for (int i = 0; i < 8; i++) begin
            e_dp = (t[i] <= 16'h007F);
            e_hp = (t[i] >= 16'h1800 && t[i] <= 16'h185F);
            acc(1, 0, 0, 0, 0, t[i], 8'(i) ^ 8'hC3);
            chk("dp", 64'(e_dp), 64'(c_dp));
            chk("hp", 64'(e_hp), 64'(c_hp));
            chk("we", 64'(e_dp | e_hp), 64'(c_we));
            acc(0, 0, 0, 0, 0, t[i], 8'h00);
            chk("rvalid", 64'h0001, 64'(c_rv));
            // reads outside the groups are compared only at FFC0, against the flash byte
            if (e_dp | e_hp) chk("rd", 64'(8'(i) ^ 8'hC3), 64'(c_rd));
            if (t[i] == 16'hFFC0) chk("rsvd", 64'(i_mem.fl_byte(t[i])), 64'(c_rd));
        end
    endtask
    task automatic t_direct();
        acc(1, 1, 0, 0, 0, 16'h1842, 8'h5E);
        chk("daddr", 64'h0042, 64'(c_ad));
        acc(0, 1, 0, 0, 0, 16'hAB42, 8'h00);
        chk("drd", 64'h005E, 64'(c_rd));
    endtask
    task automatic t_bits();
        acc(1, 0, 0, 0, 0, 16'h0033, 8'h00);
        acc(0, 0, 1, 0, 5, 16'h0033, 8'h00);
        chk("set", 64'h0120, 64'({c_we, c_wd}));
        acc(0, 0, 1, 2, 5, 16'h0033, 8'h00);
        chk("tst1", 64'h0001, 64'(c_bt));
        acc(0, 0, 1, 2, 4, 16'h0033, 8'h00);
        chk("tst0", 64'h0000, 64'(c_bt));
        acc(1, 0, 0, 0, 0, 16'h0033, 8'hFF);
        acc(0, 0, 1, 1, 0, 16'h0033, 8'h00);
        chk("clr", 64'h01FE, 64'({c_we, c_wd}));
    endtask
    task automatic t_mask();
        acc(1, 0, 0, 0, 0, 16'h1812, 8'hFF);
        reg_zero_mask_i = 8'hFC;
        acc(0, 0, 0, 0, 0, 16'h1812, 8'h00);
        chk("mask", 64'h0003, 64'(c_rd));
        reg_zero_mask_i = 8'h00;
    endtask
    task automatic t_nv();
        acc(1, 0, 0, 0, 0, 16'hFFB3, 8'h00);
        chk("nvwe", 64'h0000, 64'({c_we, c_dp, c_hp}));
        acc(0, 0, 0, 0, 0, 16'hFFB3, 8'h00);
        chk("nvrd", 64'(i_mem.fl_byte(16'hFFB3)), 64'(c_rd));
    endtask
    task automatic t_vec();
        mmvd_vec_t   s [4] = '{MMVD_VEC_RESET, MMVD_VEC_SWI, MMVD_VEC_IRQ, MMVD_VEC_LVD};
        logic [15:0] b [4] = '{16'hFFFE, 16'hFFFC, 16'hFFFA, 16'hFFF8};
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_i);
            vec_req_i = 1'b1;
            vec_sel_i = s[i];
            while (vec_valid_o !== 1'b1) @(negedge clk_i);
            vec_req_i = 1'b0;
            chk("vaddr", 64'(b[i]), 64'(vec_addr_o));
            chk("vdata", 64'({i_mem.fl_byte(b[i]), i_mem.fl_byte(b[i] + 16'h0001)}),
                64'(vec_data_o));
        end
    endtask
    initial begin
        {acc_valid_i, acc_write_i, acc_direct_i, acc_bit_op_i, vec_req_i} = '0;
        {acc_bit_cmd_i, acc_bit_sel_i, acc_addr_i, acc_wdata_i, reg_zero_mask_i} = '0;
        repeat (16) @(negedge clk_i);
        chk("prot_rst", 64'h00FF, 64'(flash_protect_byte_o));
        rst_i = 1'b0;
        t_load();
        t_map();
        t_direct();
        t_bits();
        t_mask();
        t_nv();
        t_vec();
        rst_i = 1'b1;
        repeat (3) @(negedge clk_i);
        chk("opt_rst", 64'h00FF, 64'(flash_option_byte_o));
        rst_i = 1'b0;
        t_load();
        results();
    end
endmodule
`default_nettype wire
